// ==== rtl/rcsbm_monitor.sv ====
// receive character status encoder with self-test compare monitor
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/10ps
`include "rcsbm_params.svh"

// How it works
// - independent status encoding used only when operating select is 00 or 01
// - valid data with correct disparity reports 000
// - special code, not framing nor violation, reports 001
// - elasticity buffer add/drop failure reports 010, priority 2
// - framing character reports 011 and its decoded value goes out
// - undecodable character reports 100, priority 3
// - receive PLL out of lock reports 101, priority 1
// - running disparity error reports 110 with substitute character
// - in self-test the status field shows the compare machine state
// - self-test good data compare 000, good command compare 001
// - self-test last character of sequence valid reports 010
// - self-test last character of sequence invalid reports 100
// - self-test start, lock loss or buffer fault report 101
// - self-test mismatch in any decoded bit reports 110
// - self-test comparing before start character seen reports 111
// - lock loss sends compare machine to start at once
// - errors above matches by over sixteen send machine to wait
// - buffer fault holds start status until nine characters pass
module rcsbm_monitor
  import rcsbm_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        char_valid,
  input  wire logic [7:0]  char_data,
  input  wire logic        char_is_k28_5,
  input  wire logic        char_is_comma,
  input  wire logic        char_is_special,
  input  wire logic        char_violation,
  input  wire logic        char_disparity_err,
  input  wire logic        buffer_fault,
  input  wire logic        pll_locked_pin,
  output logic             rx_char_valid,
  output logic [7:0]       rx_char_data,
  output logic [2:0]       rx_char_status_code,
  output logic             rx_clock_source_select
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] lfsr_step(input logic [7:0] v);
    lfsr_step = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr_step

  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    sat_inc = (v == 16'hffff) ? v : v + 16'h0001;
  endfunction : sat_inc

  // ----------------------------------------------------------------
  // lock pin synchroniser
  // ----------------------------------------------------------------
  logic lock_meta;
  logic lock_sync;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_meta <= 1'b0;
      lock_sync <= 1'b0;
    end else begin
      lock_meta <= pll_locked_pin;
      lock_sync <= lock_meta;
    end
  end

  wire unlock = ~lock_sync;

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic [4:0]   ctrl;
  rcsbm_state_t state;
  rcsbm_state_t next_state;
  logic [15:0]  err_cnt;
  logic [15:0]  ok_cnt;

  wire bist_en   = ctrl[`RCSBM_CTRL_BIST];
  wire [1:0] opsel = ctrl[`RCSBM_CTRL_MODE_HI:`RCSBM_CTRL_MODE_LO];
  wire fram_sel  = ctrl[`RCSBM_CTRL_FRAM];

  wire access  = psel & penable;
  wire done    = access & pready;
  wire hit_ctl = (paddr == `RCSBM_CTRL_OFS);
  wire hit_sta = (paddr == `RCSBM_STAT_OFS);
  wire hit_err = (paddr == `RCSBM_ERRCNT_OFS);
  wire hit_ok  = (paddr == `RCSBM_OKCNT_OFS);
  wire mapped  = hit_ctl | hit_sta | hit_err | hit_ok;
  // status and counters are read only; a write there is refused
  wire bad     = ~mapped | (pwrite & ~hit_ctl);
  wire wr_ctl  = done & pwrite & hit_ctl;

  wire [31:0] stat_word = {25'h0, lock_sync, state,
                           rx_char_status_code};
  wire [31:0] rd_mux = hit_ctl ? {27'h0, ctrl}    :
                       hit_sta ? stat_word        :
                       hit_err ? {16'h0, err_cnt} :
                       hit_ok  ? {16'h0, ok_cnt}  : 32'h0;

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= access & ~pready;
      pslverr <= access & ~pready & bad;
      prdata  <= (access & ~pready & ~pwrite) ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl                   <= `RCSBM_CTRL_RST;
      rx_clock_source_select <= 1'b0;
    end else if (wr_ctl) begin
      ctrl                   <= pwdata[4:0];
      rx_clock_source_select <= pwdata[`RCSBM_CTRL_CKSEL];
    end
  end

  // ----------------------------------------------------------------
  // independent mode encoding
  // ----------------------------------------------------------------
  wire indep   = (opsel == 2'b00) | (opsel == 2'b01);
  // framing selector picks full K28.5 only or any comma
  wire framing = fram_sel ? char_is_comma : char_is_k28_5;
  wire special = char_is_special & ~framing & ~char_violation;

  // priority ladder, first listed wins: unlock, buffer, violation, framing, disparity, special
  wire [2:0] ind_code =
    unlock             ? RCSBM_ST_UNLOCK  :
    buffer_fault       ? RCSBM_ST_BUFERR  :
    char_violation     ? RCSBM_ST_VIOLATE :
    framing            ? RCSBM_ST_FRAMING :
    char_disparity_err ? RCSBM_ST_DISPERR :
    special            ? RCSBM_ST_SPECIAL :
                         RCSBM_ST_NORMAL;

  // decoder already substitutes C-codes on errors; we pass it on
  wire [7:0] ind_data = char_data;

  // ----------------------------------------------------------------
  // self-test compare machine
  // ----------------------------------------------------------------
  logic [7:0] expect_data;
  logic [7:0] seq_pos;
  logic [3:0] hold_cnt;

  wire holding   = (hold_cnt != 4'h0);
  // command characters are placed where the pattern top bits are set
  wire exp_cmd   = (expect_data[7:5] == 3'b111);
  wire match     = (char_data == expect_data) &
                   (char_is_special == exp_cmd) &
                   ~char_violation & ~char_disparity_err;
  wire last_char = (seq_pos == `RCSBM_SEQ_LAST);
  wire start_chr = (char_data == `RCSBM_START_CHAR) &
                   ~char_is_special & ~char_violation;
  wire [16:0] err_w = {1'b0, err_cnt};
  wire [16:0] ok_w  = {1'b0, ok_cnt} + `RCSBM_ERR_MARGIN;
  wire too_many     = (err_w > ok_w);

  wire in_cmp = (state == RCSBM_COMPARE_STATE);
  wire cmp_ev = char_valid & in_cmp & ~unlock & ~buffer_fault;

  always_comb begin
    next_state = state;
    case (state)
      RCSBM_SELF_TEST_START_STATE: begin
        if (char_valid & ~holding & ~unlock & ~buffer_fault)
          next_state = RCSBM_AWAIT_TEST_SEQUENCE_STATE;
      end
      RCSBM_AWAIT_TEST_SEQUENCE_STATE: begin
        if (char_valid & start_chr)
          next_state = RCSBM_COMPARE_STATE;
      end
      RCSBM_COMPARE_STATE: begin
        if (too_many)
          next_state = RCSBM_AWAIT_TEST_SEQUENCE_STATE;
      end
      default: next_state = RCSBM_SELF_TEST_START_STATE;
    endcase
    if (!bist_en | unlock | buffer_fault)
      next_state = RCSBM_SELF_TEST_START_STATE;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      state <= RCSBM_SELF_TEST_START_STATE;
    else
      state <= next_state;
  end

  // recenter hold counted in received characters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      hold_cnt <= 4'h0;
    else if (buffer_fault & bist_en)
      hold_cnt <= `RCSBM_RECENTER_CHARS;
    else if (char_valid & holding)
      hold_cnt <= hold_cnt - 4'h1;
  end

  // pattern position and expected character
  wire seed_now = char_valid & start_chr &
                  ((state == RCSBM_AWAIT_TEST_SEQUENCE_STATE) |
                   (in_cmp & last_char));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      expect_data <= `RCSBM_LFSR_SEED;
      seq_pos     <= 8'h0;
    end else if (seed_now & ~(in_cmp & last_char)) begin
      expect_data <= lfsr_step(`RCSBM_LFSR_SEED);
      seq_pos     <= 8'h1;
    end else if (cmp_ev & last_char) begin
      // the next sequence must open with the start character again
      expect_data <= `RCSBM_START_CHAR;
      seq_pos     <= 8'h0;
    end else if (cmp_ev & (seq_pos == 8'h0)) begin
      expect_data <= lfsr_step(`RCSBM_LFSR_SEED);
      seq_pos     <= 8'h1;
    end else if (cmp_ev) begin
      expect_data <= lfsr_step(expect_data);
      seq_pos     <= seq_pos + 8'h1;
    end
  end

  // error and match counters, cleared outside compare
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_cnt <= 16'h0;
      ok_cnt  <= 16'h0;
    end else if (!in_cmp) begin
      err_cnt <= 16'h0;
      ok_cnt  <= 16'h0;
    end else if (cmp_ev & match) begin
      ok_cnt  <= sat_inc(ok_cnt);
    end else if (cmp_ev) begin
      err_cnt <= sat_inc(err_cnt);
    end
  end

  // ----------------------------------------------------------------
  // self-test status code
  // ----------------------------------------------------------------
  wire [2:0] cmp_code =
    last_char       ? (match ? RCSBM_ST_BUFERR
                             : RCSBM_ST_VIOLATE) :
    ~match          ? RCSBM_ST_DISPERR :
    char_is_special ? RCSBM_ST_SPECIAL :
                      RCSBM_ST_NORMAL;

  wire [2:0] bist_code =
    (unlock | buffer_fault | holding |
     (state == RCSBM_SELF_TEST_START_STATE)) ?
                    RCSBM_ST_UNLOCK :
    (state == RCSBM_AWAIT_TEST_SEQUENCE_STATE) ?
      (start_chr ? RCSBM_ST_NORMAL
                 : RCSBM_ST_WAIT) :
                    cmp_code;

  // outside independent modes the bonded encoders own the field
  wire [2:0] out_code = bist_en ? bist_code :
                        indep   ? ind_code  :
                                  RCSBM_ST_NORMAL;

  // ----------------------------------------------------------------
  // output stage, data and status share one register stage
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_char_valid       <= 1'b0;
      rx_char_data        <= 8'h0;
      rx_char_status_code <= RCSBM_ST_NORMAL;
    end else begin
      rx_char_valid <= char_valid;
      if (char_valid) begin
        rx_char_data        <= ind_data;
        rx_char_status_code <= out_code;
      end
    end
  end

endmodule : rcsbm_monitor

// ==== rtl/rcsbm_params.svh ====
// offsets, field positions, reset values and counts of the status monitor
`ifndef RCSBM_PARAMS_SVH
`define RCSBM_PARAMS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define RCSBM_CTRL_OFS     12'h000
`define RCSBM_STAT_OFS     12'h004
`define RCSBM_ERRCNT_OFS   12'h008
`define RCSBM_OKCNT_OFS    12'h00c

// ----------------------------------------------------------------
// control fields and reset value
// ----------------------------------------------------------------
`define RCSBM_CTRL_BIST    0
`define RCSBM_CTRL_MODE_LO 1
`define RCSBM_CTRL_MODE_HI 2
`define RCSBM_CTRL_FRAM    3
`define RCSBM_CTRL_CKSEL   4
`define RCSBM_CTRL_RST     5'h00

// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define RCSBM_STAT_CODE_LO 0
`define RCSBM_STAT_STATE_LO 3
`define RCSBM_STAT_LOCK    6

// ----------------------------------------------------------------
// timing and pattern counts
// ----------------------------------------------------------------
`define RCSBM_RECENTER_CHARS 4'h9
`define RCSBM_ERR_MARGIN     17'h00010
`define RCSBM_SEQ_LAST       8'hff
`define RCSBM_LFSR_SEED      8'h01
`define RCSBM_START_CHAR     8'h00

`endif

// ==== rtl/rcsbm_pkg.sv ====
// types shared by the receive status and self-test monitor
package rcsbm_pkg;

  // ----------------------------------------------------------------
  // status codes on the per-character status field
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RCSBM_ST_NORMAL   = 3'h0,
    RCSBM_ST_SPECIAL  = 3'h1,
    RCSBM_ST_BUFERR   = 3'h2,
    RCSBM_ST_FRAMING  = 3'h3,
    RCSBM_ST_VIOLATE  = 3'h4,
    RCSBM_ST_UNLOCK   = 3'h5,
    RCSBM_ST_DISPERR  = 3'h6,
    RCSBM_ST_WAIT     = 3'h7
  } rcsbm_code_t;

  // ----------------------------------------------------------------
  // self-test compare machine, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RCSBM_SELF_TEST_START_STATE       = 3'b001,
    RCSBM_AWAIT_TEST_SEQUENCE_STATE   = 3'b010,
    RCSBM_COMPARE_STATE               = 3'b100
  } rcsbm_state_t;

endpackage : rcsbm_pkg

// ==== bench/rcsbm_host.sv ====
// host model sampling receive characters with their status
`timescale 1ns/10ps
module rcsbm_host (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        rx_char_valid,
  input  wire logic [7:0]  rx_char_data,
  input  wire logic [2:0]  rx_char_status_code,
  input  wire logic        rx_clock_source_select,
  input  wire logic        far_cksel,
  output logic      [7:0]  got_data,
  output logic      [2:0]  got_code,
  output logic      [15:0] got_cnt,
  output logic             cksel_same
);
  // far end clock setup must equal ours
  assign cksel_same = (far_cksel == rx_clock_source_select);
  // status is only valid in the one pulse cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      got_data <= 8'h00;
      got_code <= 3'h0;
      got_cnt  <= 16'h0000;
    end else if (rx_char_valid) begin
      got_data <= rx_char_data;
      got_code <= rx_char_status_code;
      got_cnt  <= got_cnt + 16'h0001;
    end
  end
endmodule : rcsbm_host

// ==== bench/rcsbm_chk_monitor.sv ====
// concurrent checks on the receive status monitor ports
`timescale 1ns/10ps
module rcsbm_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        char_valid,
  input wire logic [7:0]  char_data,
  input wire logic        char_is_k28_5,
  input wire logic        char_is_comma,
  input wire logic        char_is_special,
  input wire logic        char_violation,
  input wire logic        char_disparity_err,
  input wire logic        buffer_fault,
  input wire logic        pll_locked_pin,
  input wire logic        rx_char_valid,
  input wire logic [7:0]  rx_char_data,
  input wire logic [2:0]  rx_char_status_code,
  input wire logic        rx_clock_source_select
);
  logic [4:0] ctrl;
  logic [1:0] hist;
  wire wr    = psel && penable && pready && pwrite && paddr == 12'h000;
  wire ind   = !ctrl[0] && !ctrl[2];
  wire cv    = char_valid;
  wire lk    = pll_locked_pin && (&hist);
  wire lost  = !pll_locked_pin && !(|hist);
  wire clean = !buffer_fault && !char_violation;
  wire plain = !char_is_k28_5 && !char_is_comma;
  // pin history covers the two-flop lag either way
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= 5'h00;
      hist <= 2'b00;
    end else begin
      hist <= {hist[0], pll_locked_pin};
      if (wr)
        ctrl <= pwdata[4:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_apb_wait: assert property (
    psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("apb wait state wrong");
  chk_cksel_copy: assert property (
    wr |-> ##[1:2] rx_clock_source_select == ctrl[4])
    else $error("clock select not copied");
  chk_char_next: assert property (
    cv |=> rx_char_valid && rx_char_data == $past(char_data))
    else $error("character not passed next cycle");
  chk_char_quiet: assert property (
    !cv |=> !rx_char_valid)
    else $error("spurious character");
  chk_unlock_code: assert property (
    ind && cv && lost |=> rx_char_status_code == 3'h5)
    else $error("unlock code wrong");
  chk_buffer_code: assert property (
    ind && cv && lk && buffer_fault |=> rx_char_status_code == 3'h2)
    else $error("buffer code wrong");
  chk_viol_code: assert property (
    ind && cv && lk && !buffer_fault && char_violation
      |=> rx_char_status_code == 3'h4)
    else $error("violation code wrong");
  chk_disp_code: assert property (
    ind && cv && lk && clean && plain && char_disparity_err
      |=> rx_char_status_code == 3'h6)
    else $error("disparity code wrong");
  chk_normal_code: assert property (
    ind && cv && lk && clean && plain && !char_disparity_err
      && !char_is_special |=> rx_char_status_code == 3'h0)
    else $error("normal code wrong");
  chk_start_lost: assert property (
    ctrl[0] && cv && lost |=> rx_char_status_code == 3'h5)
    else $error("self-test start on unlock wrong");
endmodule : rcsbm_chk

// ==== bench/rcsbm_monitor_bench.sv ====
// self-checking bench for the receive status and self-test monitor
`timescale 1ns/10ps
module rcsbm_monitor_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        char_valid, char_is_k28_5, char_is_comma, char_is_special;
  logic        char_violation, char_disparity_err, buffer_fault;
  logic        pll_locked_pin, rx_char_valid, rx_clock_source_select;
  logic        far_cksel, cksel_same;
  logic [7:0]  char_data, rx_char_data, got_data;
  logic [2:0]  rx_char_status_code, got_code;
  logic [15:0] got_cnt;
  int          n_errors, n_tests, cyc;
  // flags: fault, violation, k28.5, comma, special, disparity
  // the K28.5 framing entries also carry a comma, so both framing selects see them
  logic [5:0]  fl [8] = '{6'h00, 6'h02, 6'h30, 6'h0e,
                          6'h19, 6'h01, 6'h0f, 6'h03};
  logic [2:0]  ex [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6, 3'h3, 3'h6};

  rcsbm_monitor uut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .char_valid, .char_data,
    .char_is_k28_5, .char_is_comma, .char_is_special, .char_violation,
    .char_disparity_err, .buffer_fault, .pll_locked_pin, .rx_char_valid,
    .rx_char_data, .rx_char_status_code, .rx_clock_source_select);
  rcsbm_host host (.pclk, .presetn, .rx_char_valid, .rx_char_data,
    .rx_char_status_code, .rx_clock_source_select, .far_cksel,
    .got_data, .got_code, .got_cnt, .cksel_same);

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t saw %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: only the bench timeout ends a stuck wait
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask : apb

  // exp of all x skips the status compare
  task automatic ch(input logic [7:0] d, input logic [5:0] f,
                    input logic [2:0] exp);
    logic [15:0] c0;
    c0 = got_cnt;
    char_valid <= 1'b1;
    char_data <= d;
    {buffer_fault, char_violation, char_is_k28_5, char_is_comma,
     char_is_special, char_disparity_err} <= f;
    @(posedge pclk);
    {char_valid, buffer_fault} <= 2'b00;
    while (got_cnt === c0)
      @(posedge pclk);
    chk(32'(got_data), 32'(d));
    if (exp !== 3'bxxx)
      chk(32'(got_code), 32'(exp));
  endtask : ch

  task automatic lock(input logic v);
    pll_locked_pin <= v;
    repeat (3) @(posedge pclk);
  endtask : lock

  function automatic logic [7:0] step(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : step

  initial begin
    logic [31:0] r;
    logic        e, cmd, bad;
    logic [7:0]  v, x;
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {char_valid, char_data, char_is_k28_5, char_is_comma} = '0;
    {char_is_special, char_violation, char_disparity_err} = '0;
    {buffer_fault, pll_locked_pin, far_cksel} = 3'b011;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(32'(rx_char_status_code), 0);
    apb(1'b0, 12'h000, 0, r, e);
    chk(r, 0);
    apb(1'b1, 12'h000, 32'h10, r, e);
    apb(1'b0, 12'h000, 0, r, e);
    chk(r, 32'h10);
    chk(32'(cksel_same), 1);
    apb(1'b1, 12'h004, 0, r, e);
    chk(32'(e), 1);
    apb(1'b0, 12'h010, 0, r, e);
    chk({r[30:0], e}, 1);
    ch(8'h3c, 6'h06, 3'h1);
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, 12'h000, m ? 32'h0a : 32'h00, r, e);
      for (int i = 0; i < 8; i++)
        ch(8'h40 + 8'(i), fl[i], ex[i]);
    end
    ch(8'h3c, 6'h06, 3'h3);
    lock(1'b0);
    ch(8'h11, 6'h30, 3'h5);
    lock(1'b1);
    apb(1'b1, 12'h000, 32'h04, r, e);
    ch(8'h12, 6'h10, 3'h0);
    apb(1'b1, 12'h000, 32'h01, r, e);
    ch(8'h33, 6'h00, 3'h5);
    ch(8'h33, 6'h00, 3'h7);
    apb(1'b0, 12'h004, 0, r, e);
    chk(32'(r[5:3]), 2);
    ch(8'h00, 6'h00, 3'h0);
    for (int p = 0; p < 2; p++) begin
      v = 8'h01;
      for (int i = 1 - p; i < 256; i++) begin
        if (i > 0)
          v = step(v);
        x = (i > 0) ? v : 8'h00;
        cmd = (x[7:5] == 3'h7);
        bad = (i == 3 && p == 0) || (i == 255 && p == 1);
        ch(bad ? ~x : x, {4'h0, cmd, 1'b0}, i == 255 ? (bad ? 3'h4 :
           3'h2) : bad ? 3'h6 : {2'b00, cmd});
      end
    end
    // two passes: 509 good compares, two bad ones
    apb(1'b0, 12'h008, 0, r, e);
    chk(r, 32'h2);
    apb(1'b0, 12'h00c, 0, r, e);
    chk(r, 32'h1fd);
    lock(1'b0);
    ch(8'h00, 6'h00, 3'h5);
    lock(1'b1);
    ch(8'h44, 6'h00, 3'h5);
    ch(8'h00, 6'h00, 3'h0);
    v = 8'h01;
    for (int i = 0; i < 17; i++) begin
      v = step(v);
      ch(~v, 6'h00, 3'h6);
    end
    ch(~step(v), 6'h00, 3'h7);
    ch(8'h5a, 6'h00, 3'h7);
    ch(8'h00, 6'h00, 3'h0);
    ch(8'h77, 6'h20, 3'h5);
    for (int i = 0; i < 9; i++)
      ch(8'h77, 6'h00, 3'h5);
    complete_run();
  end
endmodule : rcsbm_monitor_bench

bind rcsbm_monitor rcsbm_chk chk_i (.pclk, .presetn, .paddr, .psel,
  .penable, .pwrite, .pwdata, .pready, .char_valid, .char_data,
  .char_is_k28_5, .char_is_comma, .char_is_special, .char_violation,
  .char_disparity_err, .buffer_fault, .pll_locked_pin, .rx_char_valid,
  .rx_char_data, .rx_char_status_code, .rx_clock_source_select);
